// >>> hdl/clkgen_ctrl.sv
// module: serial-programmed mode, pin, sync and lock-detect control of the clock generator
module clkgen_ctrl
  import clkgen_ctrl_pkg::*;
(
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  // serial programming pins, asynchronous to the core clock
  input  wire logic               i_ser_clk,
  input  wire logic               i_ser_data,
  input  wire logic               i_ser_le,
  // phase detector results, core clock domain
  input  wire logic               i_pd_sample,
  input  wire logic [7:0]         i_phase_error,
  input  wire logic               i_ftest,
  // two-way pins and general-purpose outputs
  input  wire logic               i_sync_pin,
  input  wire logic               i_lock_pin,
  output logic                    o_sync_pin,
  output logic                    o_sync_pin_oe,
  output logic                    o_sync_pull_up,
  output logic                    o_sync_pull_down,
  output logic                    o_lock_pin,
  output logic                    o_lock_pin_oe,
  output logic                    o_lock_pull_up,
  output logic                    o_lock_pull_down,
  output logic                    o_gp_output_zero,
  output logic                    o_gp_output_one,
  // control to the analog and divider sections
  output logic                    o_powerdown,
  output logic [1:0]              o_ref_input_range_sel,
  output logic                    o_crystal_osc_enable,
  output logic                    o_ref_doubler_enable,
  output logic [2:0]              o_filter_resistor_a,
  output logic [2:0]              o_filter_resistor_b,
  output logic [3:0]              o_filter_capacitor_a,
  output logic [3:0]              o_filter_capacitor_b,
  output logic [N_PAIRS-1:0]      o_pair_sync,
  output logic                    o_sync_active,
  output logic                    o_digital_lock_flag,
  output logic                    o_lock_pin_sense,
  output logic                    o_serial_write_lock,
  output logic                    o_soft_reset_pulse
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] ser_clk_meta;
  logic [1:0] ser_data_meta;
  logic [1:0] ser_le_meta;
  logic [1:0] sync_pin_meta;
  logic [1:0] lock_pin_meta;
  logic       ser_clk_prev;
  logic       ser_le_prev;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      ser_clk_meta  <= 2'h0;
      ser_data_meta <= 2'h0;
      ser_le_meta   <= 2'h0;
      sync_pin_meta <= 2'h0;
      lock_pin_meta <= 2'h0;
      ser_clk_prev  <= 1'b0;
      ser_le_prev   <= 1'b0;
    end
    else
    begin
      ser_clk_meta  <= {ser_clk_meta[0], i_ser_clk};
      ser_data_meta <= {ser_data_meta[0], i_ser_data};
      ser_le_meta   <= {ser_le_meta[0], i_ser_le};
      sync_pin_meta <= {sync_pin_meta[0], i_sync_pin};
      lock_pin_meta <= {lock_pin_meta[0], i_lock_pin};
      ser_clk_prev  <= ser_clk_meta[1];
      ser_le_prev   <= ser_le_meta[1];
    end
  end

  wire ser_clk_rise = ser_clk_meta[1] && !ser_clk_prev;
  wire ser_le_rise  = ser_le_meta[1] && !ser_le_prev;

  // ---------------------------------------------------------------
  // serial shift register
  // ---------------------------------------------------------------
  // shifting is held off while the latch line is high so a stray edge
  // during the latch cannot corrupt the captured word
  logic [WORD_W-1:0] shift;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      shift <= '0;
    end
    else if (ser_clk_rise && !ser_le_meta[1])
    begin
      shift <= {shift[WORD_W-2:0], ser_data_meta[1]};
    end
  end

  wire [ADDR_W-1:0] wr_addr = shift[ADDR_W-1:0];
  wire [DATA_W-1:0] wr_data = shift[WORD_W-1:ADDR_W];

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  cfg_t cfg;
  cfg_t next_cfg;

  // the lock register stays writable so a locked part can still be reopened
  wire write_ok   = ser_le_rise && (!cfg.serial_write_lock || wr_addr == ADDR_WLOCK);
  wire wr_mode    = write_ok && wr_addr == ADDR_MODE;
  wire wr_ref     = write_ok && wr_addr == ADDR_REF;
  wire wr_pins    = write_ok && wr_addr == ADDR_PINS;
  wire wr_sync    = write_ok && wr_addr == ADDR_SYNC;
  wire wr_lockdt  = write_ok && wr_addr == ADDR_LOCKDT;
  wire wr_filter  = write_ok && wr_addr == ADDR_FILTER;
  wire wr_wlock   = write_ok && wr_addr == ADDR_WLOCK;
  wire soft_reset = wr_mode && wr_data[POS_SOFT_RESET];

  always_comb
  begin
    next_cfg = cfg;
    if (soft_reset)
    begin
      next_cfg = CFG_DEFAULT;
    end
    if (wr_mode)
    begin
      next_cfg.soft_reset = wr_data[POS_SOFT_RESET];
      next_cfg.powerdown  = wr_data[POS_POWERDOWN];
    end
    if (wr_ref)
    begin
      next_cfg.ref_input_range_sel = wr_data[POS_REF_RANGE +: 2];
      next_cfg.crystal_osc_enable  = wr_data[POS_XTAL_EN];
      next_cfg.ref_doubler_enable  = wr_data[POS_DOUBLER];
    end
    if (wr_pins)
    begin
      next_cfg.lock_pin_source_sel  = wr_data[POS_LD_SRC +: 5];
      next_cfg.lock_pin_kind        = pin_kind_t'(wr_data[POS_LD_KIND +: 3]);
      next_cfg.gp_output_zero_level = wr_data[POS_GP_OUTPUT_ZERO_LEVEL];
      next_cfg.gp_output_one_level  = wr_data[POS_GP_OUTPUT_ONE_LEVEL];
    end
    if (wr_sync)
    begin
      next_cfg.sync_pin_kind        = pin_kind_t'(wr_data[POS_SYNC_KIND +: 3]);
      next_cfg.sync_active_low_sel  = wr_data[POS_SYNC_POL];
      next_cfg.sync_hold_until_lock = wr_data[POS_SYNC_HOLD];
      next_cfg.pair_sync_exclude    = wr_data[POS_PAIR_EXCL +: N_PAIRS];
    end
    if (wr_lockdt)
    begin
      next_cfg.lock_qualify_count = wr_data[POS_QUAL_CNT +: 14];
      next_cfg.phase_error_window = wr_data[POS_WINDOW +: 8];
    end
    if (wr_filter)
    begin
      next_cfg.filter_resistor_a  = wr_data[POS_RES_A +: 3];
      next_cfg.filter_resistor_b  = wr_data[POS_RES_B +: 3];
      next_cfg.filter_capacitor_a = wr_data[POS_CAP_A +: 4];
      next_cfg.filter_capacitor_b = wr_data[POS_CAP_B +: 4];
    end
    if (wr_wlock)
    begin
      next_cfg.serial_write_lock = wr_data[POS_WLOCK];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      cfg <= CFG_DEFAULT;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // ---------------------------------------------------------------
  // digital lock detect
  // ---------------------------------------------------------------
  logic digital_lock_flag;

  lock_qualifier #(
    .CNT_W (14),
    .ERR_W (8)
  ) u_lock_qualifier (
    .i_core_clk    (i_core_clk),
    .i_rstn        (i_rstn),
    .i_clear       (cfg.powerdown),
    .i_sample      (i_pd_sample),
    .i_phase_error (i_phase_error),
    .i_window      (cfg.phase_error_window),
    .i_count       (cfg.lock_qualify_count),
    .o_lock        (digital_lock_flag)
  );

  // ---------------------------------------------------------------
  // synchronisation
  // ---------------------------------------------------------------
  logic pol_prev;

  // reset value equals the configuration default, so no false toggle after reset
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      pol_prev <= CFG_DEFAULT.sync_active_low_sel;
    end
    else
    begin
      pol_prev <= cfg.sync_active_low_sel;
    end
  end

  wire sync_is_input = cfg.sync_pin_kind == PIN_IN || cfg.sync_pin_kind == PIN_IN_PU
                    || cfg.sync_pin_kind == PIN_IN_PD;
  // with the pin driven as an output there is no external sync request
  wire sync_level  = sync_is_input && (sync_pin_meta[1] ^ cfg.sync_active_low_sel);
  wire pol_toggle  = pol_prev != cfg.sync_active_low_sel;
  wire hold_lock   = cfg.sync_hold_until_lock && !digital_lock_flag;
  wire next_sync   = sync_level || pol_toggle || hold_lock;

  logic [N_PAIRS-1:0] next_pair_sync;

  genvar g;
  generate
    for (g = 0; g < N_PAIRS; g++)
    begin : g_pair
      assign next_pair_sync[g] = next_sync && !cfg.pair_sync_exclude[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // codes 6 and 7 leave the driver off, as the input kinds do: a bad write never turns a driver on
  function automatic logic [1:0] pin_drive(input pin_kind_t kind, input logic value);
    logic [1:0] r;
    r = 2'h0;
    unique case (kind)
      PIN_OUT_PP:  r = {value, 1'b1};
      PIN_OUT_INV: r = {!value, 1'b1};
      PIN_OUT_OD:  r = {1'b0, !value};
      default:     r = 2'h0;
    endcase
    return r;
  endfunction

  wire ld_src_value = cfg.lock_pin_source_sel == LDSRC_FTEST ? i_ftest
                    : cfg.lock_pin_source_sel == LDSRC_LOW   ? 1'b0
                    : cfg.lock_pin_source_sel == LDSRC_HIGH  ? 1'b1
                    : cfg.lock_pin_source_sel == LDSRC_SYNC  ? next_sync
                    : digital_lock_flag;
  wire [1:0] ld_drive   = pin_drive(cfg.lock_pin_kind, ld_src_value);
  wire [1:0] sync_drive = pin_drive(cfg.sync_pin_kind, next_sync);

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_sync_pin            <= 1'b0;
      o_sync_pin_oe         <= 1'b0;
      o_sync_pull_up        <= 1'b0;
      o_sync_pull_down      <= 1'b0;
      o_lock_pin            <= 1'b0;
      o_lock_pin_oe         <= 1'b0;
      o_lock_pull_up        <= 1'b0;
      o_lock_pull_down      <= 1'b0;
      o_gp_output_zero      <= 1'b0;
      o_gp_output_one       <= 1'b0;
      o_powerdown           <= 1'b0;
      o_ref_input_range_sel <= 2'h0;
      o_crystal_osc_enable  <= 1'b0;
      o_ref_doubler_enable  <= 1'b0;
      o_filter_resistor_a   <= 3'h0;
      o_filter_resistor_b   <= 3'h0;
      o_filter_capacitor_a  <= 4'h0;
      o_filter_capacitor_b  <= 4'h0;
      o_pair_sync           <= '0;
      o_sync_active         <= 1'b0;
      o_digital_lock_flag   <= 1'b0;
      o_lock_pin_sense      <= 1'b0;
      o_serial_write_lock   <= 1'b0;
      o_soft_reset_pulse    <= 1'b0;
    end
    else
    begin
      o_sync_pin            <= sync_drive[1];
      o_sync_pin_oe         <= sync_drive[0];
      o_sync_pull_up        <= cfg.sync_pin_kind == PIN_IN_PU;
      o_sync_pull_down      <= cfg.sync_pin_kind == PIN_IN_PD;
      o_lock_pin            <= ld_drive[1];
      o_lock_pin_oe         <= ld_drive[0];
      o_lock_pull_up        <= cfg.lock_pin_kind == PIN_IN_PU;
      o_lock_pull_down      <= cfg.lock_pin_kind == PIN_IN_PD;
      o_gp_output_zero      <= cfg.gp_output_zero_level;
      o_gp_output_one       <= cfg.gp_output_one_level;
      o_powerdown           <= cfg.powerdown;
      o_ref_input_range_sel <= cfg.ref_input_range_sel;
      o_crystal_osc_enable  <= cfg.crystal_osc_enable;
      o_ref_doubler_enable  <= cfg.ref_doubler_enable;
      o_filter_resistor_a   <= cfg.filter_resistor_a;
      o_filter_resistor_b   <= cfg.filter_resistor_b;
      o_filter_capacitor_a  <= cfg.filter_capacitor_a;
      o_filter_capacitor_b  <= cfg.filter_capacitor_b;
      o_pair_sync           <= next_pair_sync;
      o_sync_active         <= next_sync;
      o_digital_lock_flag   <= digital_lock_flag;
      o_lock_pin_sense      <= lock_pin_meta[1];
      o_serial_write_lock   <= cfg.serial_write_lock;
      o_soft_reset_pulse    <= soft_reset;
    end
  end

endmodule // clkgen_ctrl

// >>> hdl/clkgen_ctrl_pkg.sv
// package: constants, field layout and carrier types of the clock generator control block
package clkgen_ctrl_pkg;

  // ---------------------------------------------------------------
  // serial word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_W = 5;
  localparam int DATA_W = WORD_W - ADDR_W;

  localparam logic [4:0] ADDR_MODE   = 5'h00;
  localparam logic [4:0] ADDR_REF    = 5'h01;
  localparam logic [4:0] ADDR_PINS   = 5'h02;
  localparam logic [4:0] ADDR_SYNC   = 5'h03;
  localparam logic [4:0] ADDR_LOCKDT = 5'h04;
  localparam logic [4:0] ADDR_FILTER = 5'h05;
  localparam logic [4:0] ADDR_WLOCK  = 5'h1F;

  // ---------------------------------------------------------------
  // field positions (lsb within the data part of a word)
  // ---------------------------------------------------------------
  localparam int POS_SOFT_RESET = 0;
  localparam int POS_POWERDOWN  = 1;
  localparam int POS_REF_RANGE  = 0;
  localparam int POS_XTAL_EN    = 2;
  localparam int POS_DOUBLER    = 3;
  localparam int POS_LD_SRC     = 0;
  localparam int POS_LD_KIND    = 5;
  localparam int POS_GP_OUTPUT_ZERO_LEVEL       = 8;
  localparam int POS_GP_OUTPUT_ONE_LEVEL       = 9;
  localparam int POS_SYNC_KIND  = 0;
  localparam int POS_SYNC_POL   = 3;
  localparam int POS_SYNC_HOLD  = 4;
  localparam int POS_PAIR_EXCL  = 5;
  localparam int POS_QUAL_CNT   = 0;
  localparam int POS_WINDOW     = 14;
  localparam int POS_RES_A      = 0;
  localparam int POS_RES_B      = 3;
  localparam int POS_CAP_A      = 6;
  localparam int POS_CAP_B      = 10;
  localparam int POS_WLOCK      = 0;

  localparam int N_PAIRS = 6;

  // ---------------------------------------------------------------
  // pin kinds and lock pin sources
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PIN_IN      = 3'h0,
    PIN_IN_PU   = 3'h1,
    PIN_IN_PD   = 3'h2,
    PIN_OUT_PP  = 3'h3,
    PIN_OUT_OD  = 3'h4,
    PIN_OUT_INV = 3'h5
  } pin_kind_t;

  localparam logic [4:0] LDSRC_DLD   = 5'h00;
  localparam logic [4:0] LDSRC_FTEST = 5'h01;
  localparam logic [4:0] LDSRC_LOW   = 5'h02;
  localparam logic [4:0] LDSRC_HIGH  = 5'h03;
  localparam logic [4:0] LDSRC_SYNC  = 5'h04;

  typedef struct packed {
    logic              soft_reset;
    logic              powerdown;
    logic [1:0]        ref_input_range_sel;
    logic              crystal_osc_enable;
    logic              ref_doubler_enable;
    logic [4:0]        lock_pin_source_sel;
    pin_kind_t         lock_pin_kind;
    logic              gp_output_zero_level;
    logic              gp_output_one_level;
    pin_kind_t         sync_pin_kind;
    logic              sync_active_low_sel;
    logic              sync_hold_until_lock;
    logic [N_PAIRS-1:0] pair_sync_exclude;
    logic [13:0]       lock_qualify_count;
    logic [7:0]        phase_error_window;
    logic [2:0]        filter_resistor_a;
    logic [2:0]        filter_resistor_b;
    logic [3:0]        filter_capacitor_a;
    logic [3:0]        filter_capacitor_b;
    logic              serial_write_lock;
  } cfg_t;

  localparam cfg_t CFG_DEFAULT = '{
    soft_reset:           1'b0,
    powerdown:            1'b0,
    ref_input_range_sel:  2'h0,
    crystal_osc_enable:   1'b0,
    ref_doubler_enable:   1'b0,
    lock_pin_source_sel:  LDSRC_DLD,
    lock_pin_kind:        PIN_OUT_PP,
    gp_output_zero_level: 1'b0,
    gp_output_one_level:  1'b0,
    sync_pin_kind:        PIN_IN_PU,
    sync_active_low_sel:  1'b0,
    sync_hold_until_lock: 1'b0,
    pair_sync_exclude:    6'h00,
    lock_qualify_count:   14'h0400,
    phase_error_window:   8'h04,
    filter_resistor_a:    3'h0,
    filter_resistor_b:    3'h0,
    filter_capacitor_a:   4'h0,
    filter_capacitor_b:   4'h0,
    serial_write_lock:    1'b0
  };

endpackage

// >>> hdl/lock_qualifier.sv
// module: consecutive in-window phase error counter giving the digital lock flag
module lock_qualifier
  import clkgen_ctrl_pkg::*;
#(
  parameter int CNT_W = 14,
  parameter int ERR_W = 8
)(
  input  wire logic             i_core_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_clear,
  input  wire logic             i_sample,
  input  wire logic [ERR_W-1:0] i_phase_error,
  input  wire logic [ERR_W-1:0] i_window,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_lock
);

  logic [CNT_W-1:0] cnt;
  wire              in_window = i_phase_error <= i_window;
  wire  [CNT_W:0]   cnt_inc   = {1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1};
  wire              saturated = cnt >= i_count;
  wire  [CNT_W-1:0] next_cnt  = saturated ? cnt : cnt_inc[CNT_W-1:0];
  // lock once the count of good samples, this one included, reaches the setting
  wire              next_lock = cnt_inc >= {1'b0, i_count};

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn || i_clear)
    begin
      cnt    <= '0;
      o_lock <= 1'b0;
    end
    else if (i_sample && in_window)
    begin
      cnt    <= next_cnt;
      o_lock <= next_lock;
    end
    else if (i_sample)
    begin
      cnt    <= '0;
      o_lock <= 1'b0;
    end
  end

endmodule // lock_qualifier

// >>> tb/clkgen_ctrl_assertions.sv
// checker: port-level properties of the clock generator control block
module clkgen_ctrl_assertions
  import clkgen_ctrl_pkg::*;
(
  input wire logic               i_core_clk,
  input wire logic               i_rstn,
  input wire logic               i_pd_sample,
  input wire logic               o_sync_pin_oe,
  input wire logic               o_sync_pull_up,
  input wire logic               o_sync_pull_down,
  input wire logic               o_lock_pin_oe,
  input wire logic               o_lock_pull_up,
  input wire logic               o_lock_pull_down,
  input wire logic               o_powerdown,
  input wire logic [1:0]         o_ref_input_range_sel,
  input wire logic               o_ref_doubler_enable,
  input wire logic [2:0]         o_filter_resistor_a,
  input wire logic [3:0]         o_filter_capacitor_b,
  input wire logic [N_PAIRS-1:0] o_pair_sync,
  input wire logic               o_sync_active,
  input wire logic               o_digital_lock_flag,
  input wire logic               o_serial_write_lock,
  input wire logic               o_soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  reset_default_a: assert property ($rose(i_rstn) |=> o_sync_pull_up && o_lock_pin_oe)
    else $error("outputs not at defaults after reset release");
  pulse_single_a: assert property (o_soft_reset_pulse |=> !o_soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");
  soft_defaults_a: assert property (o_soft_reset_pulse |=> !o_serial_write_lock
    && !o_ref_doubler_enable && o_ref_input_range_sel == 2'h0 && o_filter_capacitor_b == 4'h0)
    else $error("soft reset left a field off its default");
  locked_reset_a: assert property (o_soft_reset_pulse |-> !$past(o_serial_write_lock))
    else $error("soft reset taken while writes were locked");
  lock_freeze_a: assert property (o_serial_write_lock && $past(o_serial_write_lock)
    |-> $stable({o_powerdown, o_ref_input_range_sel, o_filter_resistor_a}))
    else $error("configuration changed while writes were locked");
  pd_unlock_a: assert property ($rose(o_powerdown) |-> ##[1:3] !o_digital_lock_flag)
    else $error("digital lock kept through powerdown");
  lock_cause_a: assert property ($rose(o_digital_lock_flag)
    |-> $past(i_pd_sample, 2) || $past(i_pd_sample, 3))
    else $error("digital lock rose without a qualifying sample");
  pair_mask_a: assert property ((o_pair_sync & ~{N_PAIRS{o_sync_active}}) == '0)
    else $error("pair engaged without a sync event");
  lock_pin_kind_a: assert property (!(o_lock_pin_oe && (o_lock_pull_up || o_lock_pull_down)))
    else $error("lock pin driven and pulled at once");
  sync_pin_kind_a: assert property (!(o_sync_pull_up && (o_sync_pull_down || o_sync_pin_oe)))
    else $error("sync pin pull conflicts with its kind");
endmodule // clkgen_ctrl_assertions

bind clkgen_ctrl clkgen_ctrl_assertions u_chk (.i_core_clk, .i_rstn, .i_pd_sample,
  .o_sync_pin_oe, .o_sync_pull_up, .o_sync_pull_down, .o_lock_pin_oe, .o_lock_pull_up,
  .o_lock_pull_down, .o_powerdown, .o_ref_input_range_sel, .o_ref_doubler_enable,
  .o_filter_resistor_a, .o_filter_capacitor_b, .o_pair_sync, .o_sync_active,
  .o_digital_lock_flag, .o_serial_write_lock, .o_soft_reset_pulse);

// >>> tb/host_model.sv
// partner: host controller shifting words into the three-wire serial port
module host_model
  import clkgen_ctrl_pkg::*;
(
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_ser_le
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // word transfer, 160 ns bit period, clock still between frames
  // ---------------------------------------------------------------
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_le = 1'b0;
  end

  task automatic send(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [WORD_W-1:0] w;
    w = {d, a};
    #2; // step off the core clock edge
    for (int i = WORD_W - 1; i >= 0; i--)
    begin
      o_ser_data = w[i];
      #80;
      o_ser_clk = 1'b1;
      #80;
      o_ser_clk = 1'b0;
    end
    // released data line: inverse of last bit so a stale level is never trusted
    o_ser_data = ~o_ser_data;
    #80;
    o_ser_le = 1'b1;
    #80;
    o_ser_le = 1'b0;
    #80;
  endtask
endmodule // host_model

// >>> tb/testbench.sv
// testbench: self-checking bench of the clock generator control block
module testbench
  import clkgen_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) do_cmp(64'(g), 64'(e))
  logic       i_core_clk, i_rstn, i_pd_sample, i_ftest, i_sync_pin, i_lock_pin;
  logic [7:0] i_phase_error, e;
  wire        i_ser_clk, i_ser_data, i_ser_le;
  logic o_sync_pin, o_sync_pin_oe, o_sync_pull_up, o_sync_pull_down, o_lock_pin;
  logic o_lock_pin_oe, o_lock_pull_up, o_lock_pull_down, o_gp_output_zero, o_gp_output_one;
  logic o_powerdown, o_crystal_osc_enable, o_ref_doubler_enable, o_sync_active;
  logic o_digital_lock_flag, o_serial_write_lock, o_soft_reset_pulse, v, oe, o_lock_pin_sense;
  logic [1:0]         o_ref_input_range_sel;
  logic [2:0]         o_filter_resistor_a, o_filter_resistor_b;
  logic [3:0]         o_filter_capacitor_a, o_filter_capacitor_b;
  logic [N_PAIRS-1:0] o_pair_sync, ex, pg, pe;
  cfg_t               exp;
  integer             seed = 32'h7F9FABF5;
  int                 miscompares = 0, n_compared = 0, pulses = 0, act_cycles = 0, run;
  wire [21:0] got_cfg = {o_powerdown, o_ref_input_range_sel, o_crystal_osc_enable,
    o_ref_doubler_enable, o_filter_resistor_a, o_filter_resistor_b, o_filter_capacitor_a,
    o_filter_capacitor_b, o_gp_output_zero, o_gp_output_one, o_serial_write_lock};

  clkgen_ctrl DUT (.i_core_clk, .i_rstn, .i_ser_clk, .i_ser_data, .i_ser_le, .i_pd_sample,
    .i_phase_error, .i_ftest, .i_sync_pin, .i_lock_pin, .o_sync_pin, .o_sync_pin_oe,
    .o_sync_pull_up, .o_sync_pull_down, .o_lock_pin, .o_lock_pin_oe, .o_lock_pull_up,
    .o_lock_pull_down, .o_gp_output_zero, .o_gp_output_one, .o_powerdown,
    .o_ref_input_range_sel, .o_crystal_osc_enable, .o_ref_doubler_enable,
    .o_filter_resistor_a, .o_filter_resistor_b, .o_filter_capacitor_a, .o_filter_capacitor_b,
    .o_pair_sync, .o_sync_active, .o_digital_lock_flag, .o_lock_pin_sense,
    .o_serial_write_lock, .o_soft_reset_pulse);
  host_model u_host (.o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data), .o_ser_le(i_ser_le));

  // ---------------------------------------------------------------
  // clock, monitors, model and helpers
  // ---------------------------------------------------------------
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk)
  begin
    if (o_soft_reset_pulse === 1'b1) pulses <= pulses + 1;
    if (o_sync_active === 1'b1) act_cycles <= act_cycles + 1;
  end

  function automatic logic [21:0] ev(input cfg_t c);
    return {c.powerdown, c.ref_input_range_sel, c.crystal_osc_enable, c.ref_doubler_enable,
      c.filter_resistor_a, c.filter_resistor_b, c.filter_capacitor_a, c.filter_capacitor_b,
      c.gp_output_zero_level, c.gp_output_one_level, c.serial_write_lock};
  endfunction

  task automatic apply(input logic [4:0] a, input logic [26:0] d);
    if (exp.serial_write_lock && a != ADDR_WLOCK) return;
    case (a)
      ADDR_MODE:
      begin
        if (d[0]) exp = CFG_DEFAULT;
        exp.soft_reset = d[0];
        exp.powerdown = d[1];
      end
      ADDR_REF: {exp.ref_doubler_enable, exp.crystal_osc_enable, exp.ref_input_range_sel} = d[3:0];
      ADDR_PINS: {exp.gp_output_one_level, exp.gp_output_zero_level} = d[9:8];
      ADDR_FILTER: {exp.filter_capacitor_b, exp.filter_capacitor_a, exp.filter_resistor_b,
        exp.filter_resistor_a} = d[13:0];
      ADDR_WLOCK: exp.serial_write_lock = d[0];
      default: ;
    endcase
  endtask

  task automatic do_cmp(input logic [63:0] g, input logic [63:0] x);
    n_compared++;
    if (g !== x)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [26:0] d);
    apply(a, d);
    u_host.send(a, d);
    repeat (3) @(posedge i_core_clk);
    `CHK(got_cfg, ev(exp));
  endtask

  task automatic pd(input logic [7:0] err);
    @(posedge i_core_clk);
    i_pd_sample <= 1'b1;
    i_phase_error <= err;
    @(posedge i_core_clk);
    i_pd_sample <= 1'b0;
    i_phase_error <= 8'($random(seed));
    repeat (5) @(posedge i_core_clk);
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: whole sequence needs roughly a quarter of this span
  initial
  begin
    #900us;
    miscompares = miscompares + 1;
    final_report();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    i_rstn = 1'b0;
    i_pd_sample = 1'b0;
    i_phase_error = 8'h00;
    i_ftest = 1'b1;
    i_sync_pin = 1'b0;
    i_lock_pin = 1'b0;
    exp = CFG_DEFAULT;
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    `CHK({got_cfg, o_lock_pin_oe, o_sync_pull_up}, {ev(exp), 2'b11});
    for (int k = 0; k < 8; k++)
    begin
      i_lock_pin <= 1'($random(seed));
      wr(ADDR_PINS, 27'({2'($random(seed)), 3'(k), 5'(k % 4)}));
      wr(ADDR_SYNC, 27'(k));
      v = (k % 4 == 1) || (k % 4 == 3);
      oe = (k == 3 || k == 5) || (k == 4 && !v);
      pg = {o_lock_pin_oe, o_lock_pin_oe & o_lock_pin, o_lock_pull_up, o_lock_pull_down,
        o_sync_pull_up, o_sync_pull_down};
      pe = {oe, (k == 3 && v) || (k == 5 && !v), k == 1, k == 2, k == 1, k == 2};
      `CHK(pg, pe);
      `CHK({o_sync_pin_oe, o_sync_pin, o_lock_pin_sense}, {k > 2 && k < 6, k == 5, i_lock_pin});
    end
    for (int m = 0; m < 4; m++)
    begin
      ex = 6'($random(seed));
      wr(ADDR_SYNC, 27'({ex, 1'b0, m[1], 3'h1}));
      @(posedge i_core_clk);
      i_sync_pin <= m[0];
      repeat (6) @(posedge i_core_clk);
      v = m[0] ^ m[1];
      `CHK({o_sync_active, o_pair_sync}, {v, v ? ~ex : 6'h00});
    end
    // output kind keeps the level at zero, so only the toggle event shows
    wr(ADDR_SYNC, 27'h3);
    act_cycles = 0;
    wr(ADDR_SYNC, 27'hB);
    `CHK(act_cycles, 1);
    wr(ADDR_REF, 27'($random(seed)));
    wr(ADDR_FILTER, 27'($random(seed)));
    pulses = 0;
    wr(ADDR_MODE, 27'h1);
    wr(ADDR_REF, 27'hF);
    wr(ADDR_MODE, 27'h3);
    wr(ADDR_MODE, 27'h0);
    wr(ADDR_FILTER, 27'($random(seed)));
    wr(5'h07, 27'($random(seed)));
    wr(ADDR_WLOCK, 27'h1);
    wr(ADDR_REF, 27'h5);
    wr(ADDR_MODE, 27'h1);
    wr(ADDR_WLOCK, 27'h0);
    wr(ADDR_REF, 27'h6);
    `CHK(pulses, 2);
    @(posedge i_core_clk);
    i_sync_pin <= 1'b0;
    ex = 6'($random(seed));
    wr(ADDR_SYNC, 27'({ex, 1'b1, 1'b0, 3'h1}));
    wr(ADDR_LOCKDT, 27'({8'h10, 14'h5}));
    run = 0;
    for (int k = 0; k < 14; k++)
    begin
      e = (k == 7) ? 8'h11 : (k == 2) ? 8'h10 : 8'($random(seed)) & 8'h0F;
      run = (e <= 8'h10) ? run + 1 : 0;
      pd(e);
      v = run >= 5;
      `CHK({o_digital_lock_flag, o_sync_active, o_pair_sync}, {v, !v, v ? 6'h00 : ~ex});
    end
    wr(ADDR_MODE, 27'h2);
    `CHK(o_digital_lock_flag, 1'b0);
    final_report();
  end
endmodule // testbench
